// >>> common/cdlp_pkg.sv
// Constants, register map and types for the current demand and limit profiler
package cdlp_pkg;
	// ----------------------------------------
	// Widths
	// ----------------------------------------
	localparam int DW = 16;
	localparam int AW = 8;
	localparam int MIN_DIV_W = 30;
	// ----------------------------------------
	// Register offsets
	// ----------------------------------------
	localparam logic [AW-1:0] ADDR_CTRL = 8'h00;
	localparam logic [AW-1:0] ADDR_LOW_BRK = 8'h04;
	localparam logic [AW-1:0] ADDR_HIGH_BRK = 8'h08;
	localparam logic [AW-1:0] ADDR_FIRST_LIM = 8'h0C;
	localparam logic [AW-1:0] ADDR_SECOND_LIM = 8'h10;
	localparam logic [AW-1:0] ADDR_SCALER = 8'h14;
	localparam logic [AW-1:0] ADDR_MAIN_LIM = 8'h18;
	localparam logic [AW-1:0] ADDR_POS_CLAMP = 8'h1C;
	localparam logic [AW-1:0] ADDR_NEG_CLAMP = 8'h20;
	localparam logic [AW-1:0] ADDR_EXTRA = 8'h24;
	localparam logic [AW-1:0] ADDR_STATUS = 8'h28;
	localparam logic [AW-1:0] ADDR_DEMAND = 8'h2C;
	localparam logic [AW-1:0] ADDR_PROFILE = 8'h30;
	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int CTRL_W = 4;
	localparam int CTRL_ISOLATION = 0;
	localparam int CTRL_SELECTOR = 1;
	localparam int CTRL_TWO_QUADRANT = 2;
	localparam int CTRL_BIPOLAR = 3;
	localparam int STAT_AT_LIMIT = 0;
	localparam int STAT_BUSY = 1;
	localparam int STAT_TWO_QUADRANT = 2;
	// ----------------------------------------
	// Scaling, ranges and reset values (0.01 % per step)
	// ----------------------------------------
	localparam logic signed [DW-1:0] PCT_ZERO = 16'sh0000;
	localparam logic signed [DW-1:0] PCT_FULL = 16'sh2710;
	localparam logic signed [DW-1:0] PCT_MAX = 16'sh4E20;
	localparam logic signed [DW-1:0] PCT_MIN = -16'sh4E20;
	localparam logic signed [DW-1:0] MAIN_LIM_RESET = 16'sh2AF8;
	localparam logic [CTRL_W-1:0] CTRL_RESET = 4'h0;
	localparam int SCALE_DIV = 10000;
	// ----------------------------------------
	// Profiler states
	// ----------------------------------------
	typedef enum logic {CDLP_IDLE, CDLP_WAIT} cdlp_prof_e;
endpackage : cdlp_pkg

// >>> logic/cdlp_divider.sv
// Restoring serial divider used for the limit profile slope
`timescale 1ns/1ps
module cdlp_divider import cdlp_pkg::*; #(
	parameter int NW = MIN_DIV_W,
	parameter int VW = DW
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Request
	input wire logic start_i,
	input wire logic [NW-1:0] dividend_i,
	input wire logic [VW-1:0] divisor_i,
	// Result
	output logic done_o,
	output logic [NW-1:0] quotient_o
);
	localparam int LAT = NW + 1; // Start edge, NW steps, then done registered
	localparam logic [7:0] CNT_ONE = 8'h01;

	typedef struct packed {
		logic [VW:0] rem;
		logic [NW-1:0] quo;
		logic [VW-1:0] dvs;
		logic [7:0] cnt;
		logic busy;
		logic done;
	} cdlp_div_s;

	cdlp_div_s q;
	cdlp_div_s n;
	logic [VW:0] shifted;

	if (NW > 255 || NW < 2) begin : g_chk
		$error("cdlp_divider: NW out of range");
	end

	// One quotient bit per cycle
	always_comb begin
		n = q;
		n.done = 1'b0;
		shifted = {q.rem[VW-1:0], q.quo[NW-1]};
		if (q.busy) begin
			if (shifted >= {1'b0, q.dvs}) begin
				n.rem = shifted - {1'b0, q.dvs};
				n.quo = {q.quo[NW-2:0], 1'b1};
			end else begin
				n.rem = shifted;
				n.quo = {q.quo[NW-2:0], 1'b0};
			end
			n.cnt = q.cnt - CNT_ONE;
			if (q.cnt == CNT_ONE) begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
		end else if (start_i) begin
			n.rem = '0;
			n.quo = dividend_i;
			n.dvs = divisor_i;
			n.cnt = 8'(NW);
			n.busy = 1'b1;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign done_o = q.done;
	assign quotient_o = q.quo;

	// Fixed latency from start to result
	div_latency_a: assert property (@(posedge clk_i) disable iff (reset_i)
		(start_i && !q.busy) |-> ##LAT done_o)
		else $error("divider result late or early");
endmodule : cdlp_divider

// >>> logic/cdlp_current_demand.sv
// Current demand selection, clamp combination and speed-dependent limit profile
//
// Behaviour
// - Selector analogue: use second analogue input
// - Selector field: use field controller demand
// - Isolation replaces speed-loop demand
// - Stop commands cancel isolation
// - Two-quadrant blocks negative demand
// - Non-regenerative build always two-quadrant
// - Speed feedback in, limit clamp out
// - At or below low breakpoint, hold first limit
// - Linear reduction between the breakpoints
// - Above high breakpoint, hold second limit
// - First limit acts only below other clamps
// - Second limit acts only below other clamps
// - Breakpoints range 0 to 100 percent
// - Positive clamp never below negative clamp
// - Scaler multiplies both clamp inputs
// - Extra demand summed onto selected demand
//
// The implementer's own choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module cdlp_current_demand import cdlp_pkg::*; #(
	parameter bit REGEN_CAPABLE = 1'b1,
	parameter int DIV_W = MIN_DIV_W
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Register port
	input wire logic [AW-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Loop inputs, 0.01 % per step
	input wire logic signed [DW-1:0] speed_demand_i,
	input wire logic signed [DW-1:0] speed_feedback_i,
	input wire logic signed [DW-1:0] second_analogue_input_i,
	input wire logic signed [DW-1:0] field_demand_i,
	input wire logic signed [DW-1:0] overload_clamp_i,
	// Stop commands
	input wire logic program_stop_i,
	input wire logic stop_i,
	// Regulator side
	output logic signed [DW-1:0] current_demand_o,
	output logic signed [DW-1:0] pos_limit_o,
	output logic signed [DW-1:0] neg_limit_o,
	output logic signed [DW-1:0] profile_limit_o,
	output logic at_limit_o
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [CTRL_W-1:0] ctrl;
		logic signed [DW-1:0] low_speed_breakpoint;
		logic signed [DW-1:0] high_speed_breakpoint;
		logic signed [DW-1:0] first_breakpoint_limit;
		logic signed [DW-1:0] second_breakpoint_limit;
		logic signed [DW-1:0] limit_scaler;
		logic signed [DW-1:0] main_limit;
		logic signed [DW-1:0] positive_clamp_input;
		logic signed [DW-1:0] negative_clamp_input;
		logic signed [DW-1:0] extra_current_demand;
		logic [31:0] rdata;
		logic signed [DW-1:0] sel_demand;
		logic signed [DW-1:0] demand;
		logic signed [DW-1:0] pos_lim;
		logic signed [DW-1:0] neg_lim;
		logic signed [DW-1:0] profile;
		logic signed [DW-1:0] base;
		logic rising;
		logic at_limit;
		cdlp_prof_e pstate;
	} cdlp_main_s;

	cdlp_main_s q;
	cdlp_main_s n;
	logic div_start;
	logic [DIV_W-1:0] div_dividend;
	logic [DW-1:0] div_divisor;
	logic div_done;
	logic [DIV_W-1:0] div_quotient;

	if (DIV_W < MIN_DIV_W) begin : g_chk
		$error("cdlp_current_demand: DIV_W too small for the slope product");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic signed [DW-1:0] sat(input logic signed [31:0] v,
		input logic signed [DW-1:0] lo, input logic signed [DW-1:0] hi);
		if (v < 32'(lo)) begin
			return lo;
		end else if (v > 32'(hi)) begin
			return hi;
		end
		return v[DW-1:0];
	endfunction : sat

	function automatic logic signed [DW-1:0] smin(input logic signed [DW-1:0] a,
		input logic signed [DW-1:0] b);
		return (a < b) ? a : b;
	endfunction : smin

	function automatic logic signed [DW-1:0] smax(input logic signed [DW-1:0] a,
		input logic signed [DW-1:0] b);
		return (a > b) ? a : b;
	endfunction : smax

	function automatic logic signed [DW-1:0] scale(input logic signed [DW-1:0] c,
		input logic signed [DW-1:0] s);
		logic signed [31:0] p;
		p = (32'(c) * 32'(s)) / SCALE_DIV;
		return sat(p, PCT_MIN, PCT_MAX);
	endfunction : scale

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	logic stop_any;
	logic two_q;
	logic signed [DW-1:0] wval;
	logic signed [DW-1:0] spd;
	logic signed [DW-1:0] lim_diff;
	logic signed [DW-1:0] pos_s;
	logic signed [DW-1:0] neg_s;
	logic signed [DW-1:0] upper_s;
	logic signed [DW-1:0] lower_s;
	logic signed [DW-1:0] lim_all;
	logic signed [DW-1:0] summed;
	logic signed [DW-1:0] clamped;

	always_comb begin
		n = q;
		div_start = 1'b0;
		div_dividend = '0;
		div_divisor = '0;
		stop_any = program_stop_i | stop_i;
		two_q = q.ctrl[CTRL_TWO_QUADRANT] | ~REGEN_CAPABLE;
		wval = wdata_i[DW-1:0];
		spd = (speed_feedback_i < PCT_ZERO) ? -speed_feedback_i : speed_feedback_i;

		// Register writes, values saturated into their ranges
		if (wr_i) begin
			case (addr_i)
				ADDR_CTRL: n.ctrl = wdata_i[CTRL_W-1:0];
				ADDR_LOW_BRK: n.low_speed_breakpoint = sat(32'(wval), PCT_ZERO, PCT_FULL);
				ADDR_HIGH_BRK: n.high_speed_breakpoint = sat(32'(wval), PCT_ZERO, PCT_FULL);
				ADDR_FIRST_LIM: n.first_breakpoint_limit = sat(32'(wval), PCT_ZERO, PCT_MAX);
				ADDR_SECOND_LIM: n.second_breakpoint_limit = sat(32'(wval), PCT_ZERO, PCT_MAX);
				ADDR_SCALER: n.limit_scaler = sat(32'(wval), PCT_ZERO, PCT_MAX);
				ADDR_MAIN_LIM: n.main_limit = sat(32'(wval), PCT_ZERO, PCT_MAX);
				ADDR_POS_CLAMP: n.positive_clamp_input = sat(32'(wval), PCT_MIN, PCT_MAX);
				ADDR_NEG_CLAMP: n.negative_clamp_input = sat(32'(wval), PCT_MIN, PCT_MAX);
				ADDR_EXTRA: n.extra_current_demand = sat(32'(wval), PCT_MIN, PCT_MAX);
				default: ;
			endcase
		end

		// Register reads, data valid the following cycle only
		n.rdata = '0;
		if (rd_i) begin
			case (addr_i)
				ADDR_CTRL: n.rdata = 32'(q.ctrl);
				ADDR_LOW_BRK: n.rdata = {16'h0000, q.low_speed_breakpoint};
				ADDR_HIGH_BRK: n.rdata = {16'h0000, q.high_speed_breakpoint};
				ADDR_FIRST_LIM: n.rdata = {16'h0000, q.first_breakpoint_limit};
				ADDR_SECOND_LIM: n.rdata = {16'h0000, q.second_breakpoint_limit};
				ADDR_SCALER: n.rdata = {16'h0000, q.limit_scaler};
				ADDR_MAIN_LIM: n.rdata = {16'h0000, q.main_limit};
				ADDR_POS_CLAMP: n.rdata = {16'h0000, q.positive_clamp_input};
				ADDR_NEG_CLAMP: n.rdata = {16'h0000, q.negative_clamp_input};
				ADDR_EXTRA: n.rdata = {16'h0000, q.extra_current_demand};
				ADDR_STATUS: begin
					n.rdata[STAT_AT_LIMIT] = q.at_limit;
					n.rdata[STAT_BUSY] = (q.pstate == CDLP_WAIT);
					n.rdata[STAT_TWO_QUADRANT] = two_q;
				end
				ADDR_DEMAND: n.rdata = {16'h0000, q.demand};
				ADDR_PROFILE: n.rdata = {16'h0000, q.profile};
				default: n.rdata = '0;
			endcase
		end

		// Demand source: isolation picks a source unless a stop is active
		if (q.ctrl[CTRL_ISOLATION] && !stop_any) begin
			n.sel_demand = q.ctrl[CTRL_SELECTOR] ? field_demand_i
				: second_analogue_input_i;
		end else begin
			n.sel_demand = speed_demand_i;
		end

		// Sum, clamp, then block negative demand in two-quadrant mode
		summed = sat(32'(q.sel_demand) + 32'(q.extra_current_demand), PCT_MIN, PCT_MAX);
		clamped = smax(smin(summed, q.pos_lim), q.neg_lim);
		n.at_limit = (clamped != summed);
		if (two_q && clamped < PCT_ZERO) begin
			clamped = PCT_ZERO;
		end
		n.demand = clamped;

		// Clamp combination
		pos_s = scale(q.positive_clamp_input, q.limit_scaler);
		neg_s = q.ctrl[CTRL_BIPOLAR] ? scale(q.negative_clamp_input, q.limit_scaler)
			: pos_s;
		upper_s = q.ctrl[CTRL_BIPOLAR] ? smax(pos_s, -neg_s) : pos_s;
		lower_s = -neg_s;
		lim_all = smin(smin(q.main_limit, overload_clamp_i), q.profile);
		n.pos_lim = smin(upper_s, lim_all);
		n.neg_lim = smin(smax(lower_s, -lim_all), n.pos_lim);

		// Speed profile of the limit
		lim_diff = q.first_breakpoint_limit - q.second_breakpoint_limit;
		case (q.pstate)
			CDLP_IDLE: begin
				if (spd <= q.low_speed_breakpoint) begin
					n.profile = q.first_breakpoint_limit;
				end else if (q.high_speed_breakpoint <= q.low_speed_breakpoint
					|| spd >= q.high_speed_breakpoint) begin
					n.profile = q.second_breakpoint_limit;
				end else begin
					div_start = 1'b1;
					div_dividend = DIV_W'(
						(lim_diff < PCT_ZERO ? -32'(lim_diff) : 32'(lim_diff))
						* 32'(spd - q.low_speed_breakpoint));
					div_divisor = q.high_speed_breakpoint - q.low_speed_breakpoint;
					n.base = q.first_breakpoint_limit;
					n.rising = (lim_diff < PCT_ZERO);
					n.pstate = CDLP_WAIT;
				end
			end
			CDLP_WAIT: begin
				if (div_done) begin
					n.profile = q.rising ? q.base + div_quotient[DW-1:0]
						: q.base - div_quotient[DW-1:0];
					n.pstate = CDLP_IDLE;
				end
			end
			default: n.pstate = CDLP_IDLE;
		endcase
	end

	// ----------------------------------------
	// State register
	// ----------------------------------------
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			q <= '0;
			q.ctrl <= CTRL_RESET;
			q.low_speed_breakpoint <= PCT_FULL;
			q.high_speed_breakpoint <= PCT_FULL;
			q.first_breakpoint_limit <= PCT_MAX;
			q.second_breakpoint_limit <= PCT_MAX;
			q.limit_scaler <= PCT_FULL;
			q.main_limit <= MAIN_LIM_RESET;
			q.positive_clamp_input <= PCT_FULL;
			q.negative_clamp_input <= PCT_FULL;
			q.profile <= PCT_MAX;
			q.pstate <= CDLP_IDLE;
		end else begin
			q <= n;
		end
	end

	// Slope divider
	cdlp_divider #(.NW(DIV_W), .VW(DW)) u_div (
		.clk_i(clk_i),
		.reset_i(reset_i),
		.start_i(div_start),
		.dividend_i(div_dividend),
		.divisor_i(div_divisor),
		.done_o(div_done),
		.quotient_o(div_quotient)
	);

	// Outputs straight from flip-flops
	assign rdata_o = q.rdata;
	assign current_demand_o = q.demand;
	assign pos_limit_o = q.pos_lim;
	assign neg_limit_o = q.neg_lim;
	assign profile_limit_o = q.profile;
	assign at_limit_o = q.at_limit;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	src_analogue_a: assert property (
		(q.ctrl[CTRL_ISOLATION] && !q.ctrl[CTRL_SELECTOR] && !program_stop_i && !stop_i)
		|=> q.sel_demand == $past(second_analogue_input_i))
		else $error("analogue source not selected");
	src_field_a: assert property (
		(q.ctrl[CTRL_ISOLATION] && q.ctrl[CTRL_SELECTOR] && !program_stop_i && !stop_i)
		|=> q.sel_demand == $past(field_demand_i))
		else $error("field source not selected");
	speed_path_a: assert property (!q.ctrl[CTRL_ISOLATION]
		|=> q.sel_demand == $past(speed_demand_i))
		else $error("speed demand not used without isolation");
	stop_override_a: assert property ((program_stop_i || stop_i)
		|=> q.sel_demand == $past(speed_demand_i))
		else $error("stop did not restore speed demand");
	no_negative_a: assert property (two_q |=> current_demand_o >= PCT_ZERO)
		else $error("negative demand in two-quadrant mode");
	if (!REGEN_CAPABLE) begin : g_nonregen
		nonregen_a: assert property (current_demand_o >= PCT_ZERO)
			else $error("non-regenerative build passed negative demand");
	end
	profile_low_a: assert property (
		(q.pstate == CDLP_IDLE && spd <= q.low_speed_breakpoint)
		|=> profile_limit_o == $past(q.first_breakpoint_limit))
		else $error("profile not at first limit below low breakpoint");
	profile_high_a: assert property ((q.pstate == CDLP_IDLE
		&& spd > q.low_speed_breakpoint && (spd >= q.high_speed_breakpoint
		|| q.high_speed_breakpoint <= q.low_speed_breakpoint))
		|=> profile_limit_o == $past(q.second_breakpoint_limit))
		else $error("profile not at second limit");
	profile_slope_a: assert property ((q.pstate == CDLP_WAIT && div_done)
		|=> (q.rising ? profile_limit_o >= q.base : profile_limit_o <= q.base)
		&& q.pstate == CDLP_IDLE)
		else $error("interpolated limit moved the wrong way");
	clamp_order_a: assert property (pos_limit_o >= neg_limit_o)
		else $error("positive clamp below negative clamp");
	limit_min_a: assert property (1'b1 |=> pos_limit_o <= $past(q.profile)
		&& pos_limit_o <= $past(q.main_limit))
		else $error("limit exceeds a clamp");

	// Settings held inside their ranges
	brk_range_a: assert property (q.low_speed_breakpoint >= PCT_ZERO
		&& q.low_speed_breakpoint <= PCT_FULL
		&& q.high_speed_breakpoint >= PCT_ZERO
		&& q.high_speed_breakpoint <= PCT_FULL)
		else $error("speed breakpoint out of range");
	profile_range_a: assert property (profile_limit_o >= PCT_ZERO
		&& profile_limit_o <= PCT_MAX)
		else $error("profiled limit out of range");
	// A flagged demand sits on a limit or on the two-quadrant floor
	limit_flag_a: assert property (at_limit_o
		|-> current_demand_o == $past(pos_limit_o)
		|| current_demand_o == $past(neg_limit_o) || current_demand_o == PCT_ZERO)
		else $error("demand flagged at limit but not on a limit");
endmodule : cdlp_current_demand

// >>> sim/cdlp_loop_model.sv
// Speed loop and current regulator stand-in facing the demand profiler
`timescale 1ns/1ps
module cdlp_loop_model import cdlp_pkg::*; (
	// Clock and reset
	input wire logic clk_i,
	input wire logic reset_i,
	// Commands from the bench
	input wire logic signed [DW-1:0] speed_cmd_i,
	input wire logic signed [DW-1:0] feedback_cmd_i,
	// Regulator side of the profiler
	input wire logic signed [DW-1:0] current_demand_i,
	input wire logic signed [DW-1:0] pos_limit_i,
	input wire logic signed [DW-1:0] neg_limit_i,
	// Speed loop outputs
	output logic signed [DW-1:0] speed_demand_o,
	output logic signed [DW-1:0] speed_feedback_o,
	output logic demand_outside_o
);
	// Speed loop outputs registered like a real loop sample
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			speed_demand_o <= PCT_ZERO;
			speed_feedback_o <= PCT_ZERO;
		end else begin
			speed_demand_o <= speed_cmd_i;
			speed_feedback_o <= feedback_cmd_i;
		end
	end
	// Regulator notes a demand beyond its clamps
	assign demand_outside_o = (current_demand_i > pos_limit_i) || (current_demand_i < neg_limit_i);
endmodule : cdlp_loop_model

// >>> sim/cdlp_current_demand_tb_top.sv
// Self-checking bench for the current demand and limit profiler
`timescale 1ns/1ps
module cdlp_current_demand_tb_top import cdlp_pkg::*; ();
	typedef struct {int kind; string name; logic [15:0] exp;} cdlp_note_s;
	localparam int SETTLE = 2 * MIN_DIV_W + 10;
	logic clk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [AW-1:0] addr = '0;
	logic [31:0] wdata = '0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic rd_prev = 1'b0;
	logic look = 1'b0;
	logic [31:0] rdata;
	logic signed [DW-1:0] spd_cmd = '0, fbk_cmd = '0, ana = '0, fld = '0, ovl = 16'sh4E20;
	logic signed [DW-1:0] spd, fbk, cd, pl, nl, prof, cd2;
	logic pstop = 1'b0, stop = 1'b0, atl, outside;
	int n_fail = 0;
	int samples_checked = 0;
	cdlp_note_s notes[$];
	cdlp_note_s nt;
	logic [AW-1:0] ra[11] = '{ADDR_CTRL, ADDR_LOW_BRK, ADDR_HIGH_BRK, ADDR_FIRST_LIM,
		ADDR_SECOND_LIM, ADDR_SCALER, ADDR_MAIN_LIM, ADDR_POS_CLAMP, ADDR_NEG_CLAMP,
		ADDR_EXTRA, ADDR_PROFILE};
	logic [15:0] rv[11] = '{16'h0000, 16'h2710, 16'h2710, 16'h4E20, 16'h4E20, 16'h2710,
		16'h2AF8, 16'h2710, 16'h2710, 16'h0000, 16'h4E20};
	logic [15:0] fb_tab[6] = '{16'h03E8, 16'h07D0, 16'h0FA0, 16'h1388, 16'h1B58, 16'hE4A8};
	logic [15:0] pf_tab[6] = '{16'h3A98, 16'h3A98, 16'h2710, 16'h1D4C, 16'h1388, 16'h1388};
	int fb_r;
	// ----------------------------------------
	// Clock, partner and devices
	// ----------------------------------------
	always #5 clk_i = ~clk_i;
	cdlp_loop_model cdlp_loop_model_inst (.clk_i(clk_i), .reset_i(reset_i),
		.speed_cmd_i(spd_cmd), .feedback_cmd_i(fbk_cmd), .current_demand_i(cd),
		.pos_limit_i(pl), .neg_limit_i(nl), .speed_demand_o(spd), .speed_feedback_o(fbk),
		.demand_outside_o(outside));
	cdlp_current_demand cdlp_current_demand_inst (.clk_i(clk_i), .reset_i(reset_i),
		.addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
		.speed_demand_i(spd), .speed_feedback_i(fbk), .second_analogue_input_i(ana),
		.field_demand_i(fld), .overload_clamp_i(ovl), .program_stop_i(pstop), .stop_i(stop),
		.current_demand_o(cd), .pos_limit_o(pl), .neg_limit_o(nl), .profile_limit_o(prof),
		.at_limit_o(atl));
	// Build without regeneration, fed from the same inputs
	cdlp_current_demand #(.REGEN_CAPABLE(1'b0)) cdlp_current_demand_inst2 (.clk_i(clk_i),
		.reset_i(reset_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(),
		.speed_demand_i(spd), .speed_feedback_i(fbk), .second_analogue_input_i(ana),
		.field_demand_i(fld), .overload_clamp_i(ovl), .program_stop_i(pstop), .stop_i(stop),
		.current_demand_o(cd2), .pos_limit_o(), .neg_limit_o(), .profile_limit_o(),
		.at_limit_o());
	// ----------------------------------------
	// Compare, verdict and bus tasks
	// ----------------------------------------
	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : end_of_test
	task automatic wr_reg(input logic [AW-1:0] a, input logic [15:0] d);
		@(posedge clk_i);
		addr <= a;
		wdata <= {16'h0000, d};
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask : wr_reg
	task automatic rd_chk(input logic [AW-1:0] a, input logic [15:0] e, input string n);
		notes.push_back('{0, n, e});
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		@(posedge clk_i);
	endtask : rd_chk
	task automatic port_chk(input int k, input logic [15:0] e, input string n);
		notes.push_back('{k, n, e});
		@(posedge clk_i);
		look <= 1'b1;
		@(posedge clk_i);
		look <= 1'b0;
	endtask : port_chk
	task automatic settle();
		repeat (SETTLE) @(posedge clk_i);
	endtask : settle
	// ----------------------------------------
	// Output watcher: oldest note against what appears
	// ----------------------------------------
	always @(posedge clk_i) rd_prev <= rd;
	always @(negedge clk_i) begin
		if (rd_prev || look) begin
			if (notes.size() == 0) begin
				check("note queue", 32'h0000_0001, 32'h0000_0000);
			end else begin
				nt = notes.pop_front();
				case (nt.kind)
					0: check(nt.name, rdata, {16'h0000, nt.exp});
					1: check(nt.name, {16'h0000, cd}, {16'h0000, nt.exp});
					2: check(nt.name, {16'h0000, pl}, {16'h0000, nt.exp});
					3: check(nt.name, {16'h0000, nl}, {16'h0000, nt.exp});
					4: check(nt.name, {16'h0000, prof}, {16'h0000, nt.exp});
					5: check(nt.name, {31'h0, atl}, {16'h0000, nt.exp});
					7: check(nt.name, {31'h0, outside}, {16'h0000, nt.exp});
					default: check(nt.name, {16'h0000, cd2}, {16'h0000, nt.exp});
				endcase
			end
		end
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		end_of_test();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(51790));
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		// Reset values and an unmapped place
		for (int i = 0; i < 11; i++) rd_chk(ra[i], rv[i], "reset value");
		wr_reg(8'h3C, 16'h1234);
		rd_chk(8'h3C, 16'h0000, "unmapped");
		// Range saturation of settings
		wr_reg(ADDR_LOW_BRK, 16'h2EE0);
		rd_chk(ADDR_LOW_BRK, 16'h2710, "low break sat");
		wr_reg(ADDR_FIRST_LIM, 16'h61A8);
		rd_chk(ADDR_FIRST_LIM, 16'h4E20, "first limit sat");
		// Speed loop demand, extra demand, clamping
		spd_cmd <= 16'sh0BB8;
		wr_reg(ADDR_EXTRA, 16'h01F4);
		settle();
		port_chk(1, 16'h0DAC, "demand plus extra");
		spd_cmd <= 16'sh3A98;
		settle();
		port_chk(1, 16'h2710, "demand upper clamp");
		port_chk(5, 16'h0001, "at limit");
		port_chk(7, 16'h0000, "demand inside limits");
		rd_chk(ADDR_STATUS, 16'h0001, "status at limit");
		spd_cmd <= 16'shC568;
		settle();
		port_chk(1, 16'hD8F0, "demand lower clamp");
		port_chk(6, 16'h0000, "non regen demand");
		wr_reg(ADDR_EXTRA, 16'h0000);
		// Isolated sources and stop override
		ana <= 16'sh07D0;
		fld <= 16'sh0FA0;
		wr_reg(ADDR_CTRL, 16'h0001);
		settle();
		port_chk(1, 16'h07D0, "isolated analogue");
		wr_reg(ADDR_CTRL, 16'h0003);
		settle();
		port_chk(1, 16'h0FA0, "isolated field");
		stop <= 1'b1;
		settle();
		port_chk(1, 16'hD8F0, "stop override");
		stop <= 1'b0;
		pstop <= 1'b1;
		settle();
		port_chk(1, 16'hD8F0, "program stop override");
		pstop <= 1'b0;
		// Two-quadrant floor
		spd_cmd <= 16'shEC78;
		wr_reg(ADDR_CTRL, 16'h0004);
		settle();
		port_chk(1, 16'h0000, "two quadrant floor");
		rd_chk(ADDR_STATUS, 16'h0004, "status two quadrant");
		rd_chk(ADDR_DEMAND, 16'h0000, "demand readback");
		wr_reg(ADDR_CTRL, 16'h0000);
		// Speed profile below, between and above the breakpoints, and with degenerate breakpoints
		wr_reg(ADDR_LOW_BRK, 16'h07D0);
		wr_reg(ADDR_HIGH_BRK, 16'h1770);
		wr_reg(ADDR_FIRST_LIM, 16'h3A98);
		wr_reg(ADDR_SECOND_LIM, 16'h1388);
		for (int i = 0; i < 6; i++) begin
			fbk_cmd <= fb_tab[i];
			settle();
			port_chk(4, pf_tab[i], "profile table");
		end
		port_chk(2, 16'h1388, "profile in upper limit");
		for (int i = 0; i < 4; i++) begin
			fb_r = 2000 + $urandom_range(0, 4000);
			fbk_cmd <= fb_r[15:0];
			settle();
			port_chk(4, 16'(15000 - (10000 * (fb_r - 2000)) / 4000), "profile random");
		end
		wr_reg(ADDR_HIGH_BRK, 16'h03E8);
		fbk_cmd <= 16'sh09C4;
		settle();
		port_chk(4, 16'h1388, "degenerate breaks");
		// Scaler, overload and bipolar clamps
		wr_reg(ADDR_SECOND_LIM, 16'h4E20);
		wr_reg(ADDR_SCALER, 16'h1388);
		settle();
		port_chk(2, 16'h1388, "scaled upper");
		port_chk(3, 16'hEC78, "scaled lower");
		wr_reg(ADDR_SCALER, 16'h2710);
		ovl <= 16'sh0FA0;
		settle();
		port_chk(2, 16'h0FA0, "overload clamp");
		ovl <= 16'sh4E20;
		wr_reg(ADDR_CTRL, 16'h0008);
		wr_reg(ADDR_POS_CLAMP, 16'h0BB8);
		wr_reg(ADDR_NEG_CLAMP, 16'h0FA0);
		settle();
		port_chk(2, 16'h0BB8, "bipolar upper");
		port_chk(3, 16'hF060, "bipolar lower");
		wr_reg(ADDR_POS_CLAMP, 16'hE890);
		wr_reg(ADDR_NEG_CLAMP, 16'h07D0);
		settle();
		port_chk(2, 16'hF830, "crossed upper");
		port_chk(3, 16'hF830, "crossed lower");
		repeat (3) @(posedge clk_i);
		check("notes left", 32'(notes.size()), 32'h0000_0000);
		end_of_test();
	end
endmodule : cdlp_current_demand_tb_top
